// File: inc/twfq_pkg.sv
// package for the two-wire flag quirks block
package twfq_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MSTATUS = 8'h04;
  localparam logic [7:0] ADDR_SSTATUS = 8'h08;
  localparam logic [7:0] ADDR_SCMD = 8'h0C;
  localparam logic [7:0] ADDR_INST2 = 8'h10;
  // ctrl fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SDA_HOLD_SELECT = 1;
  localparam int CTRL_TIMEOUT_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // slave status fields
  localparam int ST_DIF = 0;
  localparam int ST_STOP_INTERRUPT_FLAG = 1;
  localparam int ST_SLAVE_CLOCK_HOLD_FLAG = 2;
  localparam int ST_COLL = 3;
  localparam int ST_DROPPED = 4;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  typedef enum logic [1:0] {TWFQ_UNKNOWN, TWFQ_IDLE, TWFQ_OWNER, TWFQ_BUSY} twfq_bus_t;
  typedef struct packed {
    logic start;
    logic rstart;
    logic stop;
    logic addr_match;
    logic data_byte;
    logic timeout;
    logic scl_low;
  } twfq_ev_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } twfq_apb_t;
endpackage

// File: sim/twfq_bench.sv
// self-checking bench for the two-wire flag quirks block
module two_wire_flag_quirks_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import twfq_pkg::*;
  logic pclk, presetn, pready, pslverr, scl_hold, sda_hold_select, enable, own_master, coll_detect;
  logic [31:0] prdata;
  logic [31:0] rd;
  twfq_apb_t apb;
  twfq_ev_t ev;
  int err_total, compares, cycles;
  twfq_core DUT (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .own_master(own_master), .coll_detect(coll_detect),
    .scl_hold(scl_hold), .sda_hold_select(sda_hold_select), .enable(enable));
  twfq_peer PEER (.pclk(pclk), .ev(ev), .own_master(own_master), .coll_detect(coll_detect));
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  // one setup plus access; leaves the bus up so a next setup can follow at once
  task automatic phase(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    phase(w, a, d);
    apb <= '0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic t_reset_and_ctrl();
    rchk("ctrl", ADDR_CTRL, 32'h0);
    rchk("mstatus", ADDR_MSTATUS, 32'h0);
    xfer(1'h1, ADDR_CTRL, 32'hFFFFFFFF);
    rchk("ctrl", ADDR_CTRL, 32'h7);
    chk("sda_hold_select", 32'h1, {31'h0, sda_hold_select});
    xfer(1'h1, ADDR_INST2, 32'hFFFFFFFF);
    rchk("inst2", ADDR_INST2, 32'h0);
    rchk("ctrl_kept", ADDR_CTRL, 32'h7);
    rchk("bus_state", ADDR_MSTATUS, 32'h1);
  endtask
  task automatic t_collision();
    PEER.pulse(7'h20, 1'h1);
    PEER.pulse(7'h20, 1'h0);
    rchk("coll_rstart", ADDR_SSTATUS, 32'h8);
    xfer(1'h1, ADDR_SSTATUS, 32'h8);
    rchk("coll_w1c", ADDR_SSTATUS, 32'h0);
    PEER.pulse(7'h00, 1'h1);
    PEER.pulse(7'h40, 1'h0);
    rchk("coll_start", ADDR_SSTATUS, 32'h0);
  endtask
  task automatic t_timeout_start();
    PEER.pulse(7'h00, 1'h1);
    PEER.pulse(7'h42, 1'h0);
    rchk("dropped", ADDR_SSTATUS, 32'h18);
    xfer(1'h1, ADDR_SSTATUS, 32'h18);
    rchk("drop_w1c", ADDR_SSTATUS, 32'h0);
  endtask
  task automatic t_data_and_stop();
    PEER.pulse(7'h04, 1'h0);
    rchk("dif_set", ADDR_SSTATUS, 32'h5);
    @(posedge pclk);
    phase(1'h1, ADDR_SCMD, {30'h0, CMD_RESPONSE});
    phase(1'h0, ADDR_SSTATUS, 32'h0);
    apb <= '0;
    chk("dif_lag", 32'h1, rd);
    @(posedge pclk);
    rchk("dif_clear", ADDR_SSTATUS, 32'h0);
    PEER.pulse(7'h10, 1'h0);
    rchk("stop_idle", ADDR_MSTATUS, 32'h1);
    rchk("stop_interrupt_flag_noclkhold", ADDR_SSTATUS, 32'h2);
    xfer(1'h1, ADDR_SSTATUS, 32'h2);
    rchk("stop_interrupt_flag_clear", ADDR_SSTATUS, 32'h0);
    chk("scl_hold", 32'h0, {31'h0, scl_hold});
    fork
      xfer(1'h1, ADDR_SSTATUS, 32'h2);
      begin
        @(posedge pclk);
        PEER.pulse(7'h08, 1'h0);
      end
    join
    rchk("race_stuck", ADDR_SSTATUS, 32'h6);
    chk("scl_held", 32'h1, {31'h0, scl_hold});
    xfer(1'h1, ADDR_SCMD, {30'h0, CMD_RESPONSE});
    xfer(1'h1, ADDR_SSTATUS, 32'h2);
    rchk("race_freed", ADDR_SSTATUS, 32'h0);
    chk("scl_freed", 32'h0, {31'h0, scl_hold});
  endtask
  initial begin
    presetn = 1'h0;
    apb = '0;
    err_total = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_reset_and_ctrl();
    t_collision();
    t_timeout_start();
    t_data_and_stop();
    report_and_stop();
  end
endmodule

// File: sim/twfq_peer.sv
// far-side bus peer model: drives bus events into the block
module twfq_peer
  import twfq_pkg::*;
(
  input wire logic pclk,
  output twfq_pkg::twfq_ev_t ev,
  output logic own_master,
  output logic coll_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  import twfq_pkg::*;
  initial begin
    ev = '0;
    own_master = 1'h0;
    coll_detect = 1'h0;
  end
  // events are strictly one cycle wide, as the bus side reports them
  task automatic pulse(input twfq_ev_t e, input logic c);
    @(posedge pclk);
    ev <= e;
    coll_detect <= c;
    @(posedge pclk);
    ev <= '0;
    coll_detect <= 1'h0;
  endtask
endmodule

// File: verilog/twfq_bus_tracker.sv
// bus state tracker: idle, owned, busy, unknown
module twfq_bus_tracker
  import twfq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire twfq_pkg::twfq_ev_t ev,
  input wire logic own_master,
  output twfq_pkg::twfq_bus_t state
);
  import twfq_pkg::*;
  typedef struct packed {
    twfq_bus_t state;
  } twfq_trk_t;
  twfq_trk_t r;
  twfq_trk_t next_r;
  always_comb begin
    next_r = r;
    if (!enable) begin
      next_r.state = TWFQ_UNKNOWN;
    end else if (ev.stop || ev.timeout) begin
      next_r.state = TWFQ_IDLE;
    end else if (ev.start || ev.rstart) begin
      next_r.state = own_master ? TWFQ_OWNER : TWFQ_BUSY;
    end else if (r.state == TWFQ_UNKNOWN) begin
      next_r.state = TWFQ_IDLE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: TWFQ_UNKNOWN};
    end else begin
      r <= next_r;
    end
  end
  assign state = r.state;
endmodule

// File: verilog/twfq_core.sv
// two-wire status flag logic with revision quirks, APB slave
// Function
// - a START clears the transmit collision flag but a repeated START leaves it set.
// - a stop flag clear colliding with an address-match set leaves clock hold stuck and SCL held.
// - a timeout in the same cycle as a detected START drops that transaction.
// - the response command clears the data flag one cycle later, so an immediate read still shows it.
// - the SDA hold select is a single control bit.
// - the second instance is absent; writes to it act like writes to a reserved location.
//
// Chosen here: the APB register port and the address map.
module twfq_core
  import twfq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire twfq_pkg::twfq_apb_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire twfq_pkg::twfq_ev_t ev,
  input wire logic own_master,
  input wire logic coll_detect,
  output logic scl_hold,
  output logic sda_hold_select,
  output logic enable
);
  import twfq_pkg::*;
  typedef struct packed {
    logic [2:0] ctrl;
    logic data_interrupt_flag;
    logic stop_interrupt_flag;
    logic slave_clock_hold_flag;
    logic coll;
    logic dropped;
    logic dif_clr_pend;
    logic [31:0] rdata;
  } twfq_st_t;
  twfq_st_t r;
  twfq_st_t next_r;
  twfq_bus_t bus_state;
  logic wr;
  logic rd;
  logic stop_interrupt_flag_wr_clr;
  logic addr_set;
  logic start_ok;
  logic resp_cmd;
  logic stop_set;
  logic data_set;
  logic drop_evt;

  twfq_bus_tracker u_trk (
    .pclk(pclk),
    .presetn(presetn),
    .enable(r.ctrl[CTRL_EN]),
    .ev(ev),
    .own_master(own_master),
    .state(bus_state)
  );

  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = apb.psel && apb.penable && apb.pwrite;
  assign rd = apb.psel && !apb.penable && !apb.pwrite;
  assign stop_interrupt_flag_wr_clr = wr && apb.paddr == ADDR_SSTATUS && apb.pwdata[ST_STOP_INTERRUPT_FLAG];
  assign addr_set = ev.addr_match && r.ctrl[CTRL_EN];
  // coincident timeout swallows the start
  assign start_ok = ev.start && !(r.ctrl[CTRL_TIMEOUT_EN] && ev.timeout);
  assign resp_cmd = wr && apb.paddr == ADDR_SCMD && apb.pwdata[1:0] == CMD_RESPONSE;
  assign stop_set = ev.stop && r.ctrl[CTRL_EN];
  assign data_set = ev.data_byte && r.ctrl[CTRL_EN];
  // only armed while timeout detection is on
  assign drop_evt = ev.start && ev.timeout && r.ctrl[CTRL_TIMEOUT_EN];

  always_comb begin
    next_r = r;
    // data flag clear lags the command by a cycle
    next_r.dif_clr_pend = 1'b0;
    if (r.dif_clr_pend) begin
      next_r.data_interrupt_flag = 1'b0;
    end
    if (wr) begin
      unique case (apb.paddr)
        ADDR_CTRL: next_r.ctrl = apb.pwdata[2:0];
        ADDR_SSTATUS: begin
          if (apb.pwdata[ST_DIF]) next_r.data_interrupt_flag = 1'b0;
          if (apb.pwdata[ST_COLL]) next_r.coll = 1'b0;
          if (apb.pwdata[ST_DROPPED]) next_r.dropped = 1'b0;
          if (apb.pwdata[ST_STOP_INTERRUPT_FLAG]) next_r.stop_interrupt_flag = 1'b0;
        end
        ADDR_SCMD: begin
          if (apb.pwdata[1:0] == CMD_RESPONSE) begin
            next_r.dif_clr_pend = 1'b1;
            next_r.slave_clock_hold_flag = 1'b0;
          end
        end
        default: ; // second instance and holes ignored
      endcase
    end
    // clearing stop_interrupt_flag normally also releases the clock hold
    if (stop_interrupt_flag_wr_clr && !addr_set) begin
      next_r.slave_clock_hold_flag = 1'b0;
    end
    if (start_ok) begin
      next_r.coll = 1'b0;
    end
    if (drop_evt) begin
      next_r.dropped = 1'b1;
    end
    if (coll_detect) begin
      next_r.coll = 1'b1;
    end
    if (stop_set) begin
      next_r.stop_interrupt_flag = 1'b1;
    end
    // hardware set wins; slave_clock_hold_flag stays set and bus locks on collision
    if (addr_set) begin
      next_r.stop_interrupt_flag = 1'b1;
      next_r.slave_clock_hold_flag = 1'b1;
    end
    if (data_set) begin
      next_r.data_interrupt_flag = 1'b1;
      next_r.slave_clock_hold_flag = 1'b1;
    end
    next_r.rdata = '0;
    if (rd) begin
      unique case (apb.paddr)
        ADDR_CTRL: next_r.rdata = {29'h0, r.ctrl};
        ADDR_MSTATUS: next_r.rdata = {30'h0, bus_state};
        ADDR_SSTATUS: next_r.rdata = {27'h0, r.dropped, r.coll, r.slave_clock_hold_flag, r.stop_interrupt_flag, r.data_interrupt_flag};
        default: next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ctrl: CTRL_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign scl_hold = r.slave_clock_hold_flag;
  assign sda_hold_select = r.ctrl[CTRL_SDA_HOLD_SELECT];
  assign enable = r.ctrl[CTRL_EN];

  // multi-step behaviours as named sequences
  sequence s_resp_issue;
    resp_cmd && r.data_interrupt_flag && !ev.data_byte;
  endsequence
  sequence s_dif_lags;
    r.data_interrupt_flag ##1 (!r.data_interrupt_flag || $past(ev.data_byte));
  endsequence
  sequence s_stop_interrupt_flag_race;
    stop_interrupt_flag_wr_clr && addr_set;
  endsequence
  sequence s_hold_stuck;
    scl_hold && r.stop_interrupt_flag;
  endsequence

  a_dif_clear_lag: assert property (@(posedge pclk) disable iff (!presetn)
    s_resp_issue |=> s_dif_lags)
    else $error("data flag clear lag wrong");
  a_dif_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    data_set |=> r.data_interrupt_flag)
    else $error("data flag not set by data byte");
  a_resp_frees_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (resp_cmd && !addr_set && !data_set) |=> !scl_hold)
    else $error("response command kept clock hold");
  a_coll_start_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && !coll_detect) |=> !r.coll)
    else $error("collision flag not cleared on start");
  a_coll_rstart_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (r.coll && ev.rstart && !ev.start && !wr) |=> r.coll)
    else $error("collision cleared on repeated start");
  a_coll_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    coll_detect |=> r.coll)
    else $error("collision flag not set");
  a_race_holds_scl: assert property (@(posedge pclk) disable iff (!presetn)
    s_stop_interrupt_flag_race |=> s_hold_stuck)
    else $error("race did not keep clock hold");
  a_addr_sets_hold: assert property (@(posedge pclk) disable iff (!presetn)
    addr_set |=> s_hold_stuck)
    else $error("address match did not hold clock");
  a_stop_interrupt_flag_clr_release: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_interrupt_flag_wr_clr && !addr_set && !data_set) |=> !scl_hold)
    else $error("stop flag clear kept clock hold");
  a_stop_sets_stop_interrupt_flag: assert property (@(posedge pclk) disable iff (!presetn)
    stop_set |=> r.stop_interrupt_flag)
    else $error("stop flag not set on stop");
  a_timeout_drop: assert property (@(posedge pclk) disable iff (!presetn)
    drop_evt |=> r.dropped)
    else $error("dropped not flagged");
  a_drop_keeps_coll: assert property (@(posedge pclk) disable iff (!presetn)
    (drop_evt && r.coll && !wr) |=> r.coll)
    else $error("dropped start cleared collision flag");
  a_no_drop_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.dropped && !drop_evt) |=> !r.dropped)
    else $error("dropped flagged without timeout at start");
  a_sda_hold_select_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && apb.paddr == ADDR_CTRL) |=> sda_hold_select == $past(apb.pwdata[CTRL_SDA_HOLD_SELECT]))
    else $error("sda hold bit");
  a_sda_hold_select_one_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && apb.paddr == ADDR_CTRL) |=> prdata[31:3] == 29'h0)
    else $error("control read shows wide field");
  a_inst2_noeffect: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && apb.paddr == ADDR_INST2) |=> $stable(r.ctrl))
    else $error("second instance write had effect");
  a_inst2_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && apb.paddr == ADDR_INST2) |=> prdata == 32'h0)
    else $error("second instance read not zero");
  a_bus_state_field_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && apb.paddr == ADDR_MSTATUS) |=> prdata[1:0] == $past(bus_state))
    else $error("bus state read wrong");
  a_bus_idle_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (r.ctrl[CTRL_EN] && (ev.stop || ev.timeout)) |=> bus_state == TWFQ_IDLE)
    else $error("bus state not idle after stop");
  a_bus_off_unknown: assert property (@(posedge pclk) disable iff (!presetn)
    !r.ctrl[CTRL_EN] |=> bus_state == TWFQ_UNKNOWN)
    else $error("bus state known while disabled");
endmodule
